// ---- shared/acs_pkg.sv ----
// shared constants, types and helpers of the converter sequencer
package acs_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] CTL0_IDX = 8'h9D; // converter_control_0
  localparam logic [7:0] CTL1_IDX = 8'h9C; // converter_control_1
  localparam logic [7:0] RESH_IDX = 8'h9E; // result_high_byte
  localparam logic [7:0] RESL_IDX = 8'h9F; // result_low_byte
  localparam logic [7:0] FLAG_IDX = 8'h0C; // peripheral_flag_reg
  localparam logic [7:0] IEN_IDX  = 8'h8C; // peripheral_enable_reg

  // converter_control_0 fields
  localparam int ON_BIT  = 0; // converter_on
  localparam int GO_BIT  = 1; // go / busy
  localparam int CHAN_LSB = 2; // channel_sel[3:0]
  localparam int DIV_LSB = 6; // conv_clock_div_sel
  // converter_control_1 fields
  localparam int LDOSEL_BIT  = 0; // internal reference level select
  localparam int LDOEN_BIT   = 2; // internal reference enable
  localparam int CHAN4_BIT   = 6; // channel_sel[4]
  localparam int JUSTIFY_BIT = 7; // result_justify_sel
  // done flag and its enable share one bit position
  localparam int DONE_BIT = 6;

  // reset values
  localparam logic [7:0]  CTL0_RST = 8'h00;
  localparam logic [7:0]  CTL1_RST = 8'h00;
  localparam logic [7:0]  RES_RST  = 8'h00;
  localparam logic [11:0] SAR_RST  = 12'h000;

  // sequence timing, in conversion-clock periods
  localparam logic [5:0] PERIODS_TOTAL  = 6'h31; // 49 periods per conversion
  localparam logic [5:0] SAMPLE_PERIODS = 6'h24; // 36 periods of acquisition
  localparam logic [5:0] SAR_BITS       = 6'h0C; // 12 bit trials
  localparam logic [5:0] ABORT_PERIODS  = 6'h02; // wait after an abort

  // channel code that routes the fixed reference
  localparam logic [4:0] REF_CHANNEL = 5'h12;

  // sequencer states
  typedef enum logic [1:0] {st_idle, st_run, st_holdoff} acs_state_t;

  // system clocks per conversion-clock period
  function automatic logic [7:0] acs_divisor(input logic [1:0] sel);
    case (sel)
      2'h0:    acs_divisor = 8'h08;
      2'h1:    acs_divisor = 8'h10;
      2'h2:    acs_divisor = 8'h20;
      default: acs_divisor = 8'h80;
    endcase
  endfunction

endpackage

// ---- hw/acs_tad_divider.sv ----
// conversion-clock divider: one tick per bit period
`timescale 1ns/100ps
module acs_period_divider
  import acs_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_reset,
  input  wire logic       i_run,     // count while high, restart when low
  input  wire logic [1:0] i_div_sel, // latched divide select
  output logic            o_tick     // last system clock of a period
);

  typedef struct packed {
    logic [7:0] count; // system clocks into current period
  } acs_div_t;

  acs_div_t r;      // registered state
  acs_div_t next_r; // next state

  // tick on the last cycle of each period
  assign o_tick = i_run && (r.count == acs_divisor(i_div_sel) - 8'h01);

  // counter restarts whenever idle, so the first period is a full one
  always_comb begin
    next_r = r;
    if (!i_run || o_tick) begin
      next_r.count = 8'h00;
    end else begin
      next_r.count = r.count + 8'h01;
    end
  end

  // state register
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ticks never fall on two adjacent cycles
  AST_TICK_SPACING: assert property (@(posedge i_clock) disable iff (i_reset)
    o_tick |=> !o_tick)
    else $error("divider ticked on two adjacent cycles");

endmodule

// ---- hw/acs_top.sv ----
// converter sequencer: register file, bit-period sequencing, result formatting
`timescale 1ns/100ps
module acs_top
  import acs_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_sleep,        // device in sleep mode
  input  wire logic        i_comp_high,    // input at or above trial code
  output logic             o_converter_on, // analog power
  output logic             o_sample,       // sample-and-hold tracking
  output logic [4:0]       o_channel_sel,  // mux select
  output logic             o_ref_to_sh,    // fixed reference routed
  output logic [11:0]      o_dac_code,     // trial code to the comparator
  output logic             o_ref_ldo_en,   // internal reference enable
  output logic             o_ref_ldo_sel,  // internal reference level
  output logic             o_peripheral_irq
);

  // all state of the block
  typedef struct packed {
    acs_state_t  state;   // sequencer state
    logic        on;      // converter_on
    logic        go;      // go / busy bit
    logic [4:0]  chan;    // channel_sel
    logic [1:0]  div_sel; // conv_clock_div_sel as written
    logic [1:0]  run_div; // divide select frozen for this conversion
    logic        justify; // result_justify_sel
    logic        ldo_en;  // internal reference enable
    logic        ldo_sel; // internal reference level
    logic [5:0]  period;  // bit periods elapsed
    logic [11:0] sar;     // approximation register
    logic [7:0]  res_hi;  // result_high_byte
    logic [7:0]  res_lo;  // result_low_byte
    logic        done;    // conversion_done_flag
    logic        irq_en;  // conversion_irq_enable
    logic [31:0] rdata;   // read data captured in setup phase
  } acs_regs_t;

  acs_regs_t r;      // registered state
  acs_regs_t next_r; // next state
  logic      tick;   // end of a bit period

  // bus phase decode
  logic       setup;    // first cycle of a transfer
  logic       access;   // second cycle, always ready
  logic       wr_en;    // write takes effect now
  logic [7:0] idx;      // word index of the address
  logic       mapped;   // address hits a register
  logic       complete; // final period of a conversion ends
  logic [5:0] bit_pos;  // trial bit of the current period

  assign setup  = i_psel && !i_penable;
  assign access = i_psel && i_penable;
  assign wr_en  = access && i_pwrite && mapped;
  assign idx    = i_paddr[9:2];
  assign mapped = (i_paddr[11:10] == 2'h0) && (i_paddr[1:0] == 2'h0) &&
                  (idx == CTL0_IDX || idx == CTL1_IDX || idx == RESH_IDX ||
                   idx == RESL_IDX || idx == FLAG_IDX || idx == IEN_IDX);
  assign complete = (r.state == st_run) && tick && (r.period == PERIODS_TOTAL - 6'h01);
  assign bit_pos  = 6'h0B - (r.period - SAMPLE_PERIODS);

  // the slave never inserts wait states; unmapped words answer an error
  assign o_pready  = access;
  assign o_pslverr = access && !mapped;
  assign o_prdata  = r.rdata;

  // analog side
  assign o_converter_on = r.on;
  assign o_channel_sel  = r.chan;
  assign o_ref_to_sh    = (r.chan == REF_CHANNEL);
  assign o_dac_code     = r.sar;
  assign o_ref_ldo_en   = r.ldo_en;
  assign o_ref_ldo_sel  = r.ldo_sel;
  // tracking runs while idle and in the acquisition part; off during abort wait
  assign o_sample = r.on && !i_sleep &&
                    (r.state == st_idle || (r.state == st_run && r.period < SAMPLE_PERIODS));
  assign o_peripheral_irq = r.done && r.irq_en;

  // bit-period divider runs only while a sequence is active
  acs_period_divider u_div (
    .i_clock   (i_clock),
    .i_reset   (i_reset),
    .i_run     (r.state != st_idle),
    .i_div_sel (r.run_div),
    .o_tick    (tick)
  );

  // next-state logic: bus writes first, hardware events override
  always_comb begin
    next_r = r;
    // read data is taken in the setup cycle so it comes from a flop
    if (setup && !i_pwrite) begin
      next_r.rdata = 32'h0000_0000;
      case (idx)
        CTL0_IDX: next_r.rdata[7:0] = {r.div_sel, r.chan[3:0], r.go, r.on};
        CTL1_IDX: next_r.rdata[7:0] = {r.justify, r.chan[4], 3'h0, r.ldo_en, 1'h0, r.ldo_sel};
        RESH_IDX: next_r.rdata[7:0] = r.res_hi;
        RESL_IDX: next_r.rdata[7:0] = r.res_lo;
        FLAG_IDX: next_r.rdata[DONE_BIT] = r.done;
        IEN_IDX:  next_r.rdata[DONE_BIT] = r.irq_en;
        default:  next_r.rdata = 32'h0000_0000;
      endcase
    end
    // register writes
    if (wr_en) begin
      case (idx)
        CTL0_IDX: begin
          next_r.div_sel  = i_pwdata[DIV_LSB +: 2];
          next_r.chan[3:0] = i_pwdata[CHAN_LSB +: 4];
          next_r.on        = i_pwdata[ON_BIT];
          if (r.state == st_idle) begin
            // start only if already on before this write
            if (i_pwdata[GO_BIT] && r.on && i_pwdata[ON_BIT] && !i_sleep) begin
              next_r.go      = 1'b1;
              next_r.state   = st_run;
              next_r.period  = 6'h00;
              next_r.run_div = i_pwdata[DIV_LSB +: 2];
              next_r.sar     = SAR_RST;
            end
          end else if (r.state == st_run && !i_pwdata[GO_BIT] && !complete) begin
            // software abort: result bytes untouched
            next_r.go     = 1'b0;
            next_r.state  = st_holdoff;
            next_r.period = 6'h00;
          end
          // a go write while running does not restart it; div_sel, chan[3:0] and on still take the written values
        end
        CTL1_IDX: begin
          next_r.justify = i_pwdata[JUSTIFY_BIT];
          next_r.chan[4] = i_pwdata[CHAN4_BIT];
          next_r.ldo_en  = i_pwdata[LDOEN_BIT];
          next_r.ldo_sel = i_pwdata[LDOSEL_BIT];
        end
        FLAG_IDX: next_r.done   = i_pwdata[DONE_BIT];
        IEN_IDX:  next_r.irq_en = i_pwdata[DONE_BIT];
        default:  next_r.on     = next_r.on; // result bytes are read only
      endcase
    end
    // sequencer
    case (r.state)
      st_idle: begin
        next_r.period = next_r.period;
      end
      st_run: begin
        if (tick) begin
          next_r.period = r.period + 6'h01;
          if (r.period == SAMPLE_PERIODS - 6'h01) begin
            // hold taken; first trial sets the top bit
            next_r.sar = 12'h800;
          end else if (r.period >= SAMPLE_PERIODS && r.period < SAMPLE_PERIODS + SAR_BITS) begin
            // keep or drop the trial bit, then try the next one
            next_r.sar[bit_pos[3:0]] = i_comp_high;
            if (bit_pos != 6'h00) begin
              next_r.sar[bit_pos[3:0] - 4'h1] = 1'b1;
            end
          end
        end
        if (complete) begin
          // completion: clear go, set flag, load result
          next_r.go     = 1'b0;
          next_r.state  = st_idle;
          next_r.period = 6'h00;
          next_r.done   = 1'b1;
          if (r.justify) begin
            // right aligned, top ten bits kept
            next_r.res_hi = {6'h00, r.sar[11:10]};
            next_r.res_lo = r.sar[9:2];
          end else begin
            // left aligned, all twelve bits
            next_r.res_hi = r.sar[11:4];
            next_r.res_lo = {r.sar[3:0], 4'h0};
          end
        end
      end
      st_holdoff: begin
        // two idle periods before tracking resumes by itself
        if (tick) begin
          next_r.period = r.period + 6'h01;
          if (r.period == ABORT_PERIODS - 6'h01) begin
            next_r.state  = st_idle;
            next_r.period = 6'h00;
          end
        end
      end
      default: begin
        next_r.state = st_idle;
      end
    endcase
    // turning off or entering sleep ends any sequence at once
    if (!next_r.on || i_sleep) begin
      next_r.state  = st_idle;
      next_r.go     = 1'b0;
      next_r.period = 6'h00;
    end
  end

  // state register; reset returns every control bit
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      r         <= '0;
      r.state   <= st_idle;
      r.on      <= CTL0_RST[ON_BIT];
      r.go      <= CTL0_RST[GO_BIT];
      r.res_hi  <= RES_RST;
      r.res_lo  <= RES_RST;
      r.justify <= CTL1_RST[JUSTIFY_BIT];
      r.sar     <= SAR_RST;
    end else begin
      r <= next_r;
    end
  end

  // ---- checks ----
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  // helper: system cycles since entering the run state
  logic [13:0] run_cycles;
  always_ff @(posedge i_clock) begin
    if (i_reset || r.state != st_run) begin
      run_cycles <= 14'h0000;
    end else begin
      run_cycles <= run_cycles + 14'h0001;
    end
  end

  AST_CONV_LENGTH: assert property (complete |->
    run_cycles == 14'(49 * acs_divisor(r.run_div)) - 14'h0001)
    else $error("conversion length is not 49 bit periods");
  AST_START_NEEDS_ON: assert property ($rose(r.go) |-> $past(r.on))
    else $error("conversion started without converter already on");
  AST_NO_START_OFF: assert property (!r.on && r.state == st_idle |=> r.state == st_idle)
    else $error("conversion started while off");
  AST_DONE_AT_END: assert property (complete |=> r.done && !r.go && r.state == st_idle)
    else $error("completion did not set flag and clear go");
  AST_DONE_STICKY: assert property (r.done && !(wr_en && idx == FLAG_IDX) |=> r.done)
    else $error("done flag cleared without software write");
  AST_IRQ: assert property (o_peripheral_irq == (r.done && r.irq_en))
    else $error("interrupt request does not follow flag and enable");
  AST_ABORT_KEEPS: assert property ($fell(r.go) && r.state == st_holdoff |->
    $stable(r.res_hi) && $stable(r.res_lo))
    else $error("abort changed the result bytes");
  AST_HOLDOFF_NO_SAMPLE: assert property (r.state == st_holdoff |-> !o_sample)
    else $error("tracking resumed before abort wait ended");
  AST_JUSTIFY_RIGHT: assert property (complete && r.justify |=> r.res_hi[7:2] == 6'h00)
    else $error("right aligned result has bits above bit 1");
  AST_SLEEP: assert property (i_sleep |=> r.state == st_idle && !r.go)
    else $error("converter runs in sleep");

  COV_COMPLETE: cover property (complete && !r.irq_en);
  COV_ABORT: cover property (r.state == st_run ##1 r.state == st_holdoff);
  COV_RESTART: cover property (r.state == st_holdoff ##1 r.state == st_idle);
  COV_REF: cover property (complete && o_ref_to_sh);

endmodule

// ---- sim/acs_analog_model.sv ----
// analog side model: input channels, shared sample-and-hold and comparator
`timescale 1ns/100ps
module acs_analog_model
  import acs_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_sample,      // hold tracks while high
  input  wire logic [4:0]  i_channel_sel, // selected input
  input  wire logic [11:0] i_dac_code,    // trial code
  output logic             o_comp_high    // input at or above trial code
);
  logic [11:0] held; // voltage frozen on the hold capacitor

  // each channel carries its own level, so a wrong mux shows in the result
  always_ff @(posedge i_clock) begin
    if (i_sample) begin // tracks only while acquiring
      held <= {i_channel_sel, 7'h35};
    end
  end

  // ideal comparator; the held value stays put once tracking stops
  assign o_comp_high = (held >= i_dac_code);
endmodule

// ---- sim/acs_top_tb.sv ----
// self-checking bench of the converter sequencer
`timescale 1ns/100ps
module acs_top_tb;
  import acs_pkg::*;
  logic        i_clock, i_reset, i_psel, i_penable, i_pwrite, i_sleep;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic        o_pready, o_pslverr, err, comp, on, samp, ref_sh, ldo_en, ldo_sel, irq;
  logic [4:0]  chan;
  logic [11:0] dac, last; // last holds the newest completed sample
  int          n_errors, num_checks;

  acs_top DUT (.i_clock(i_clock), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_sleep(i_sleep), .i_comp_high(comp),
    .o_converter_on(on), .o_sample(samp), .o_channel_sel(chan), .o_ref_to_sh(ref_sh),
    .o_dac_code(dac), .o_ref_ldo_en(ldo_en), .o_ref_ldo_sel(ldo_sel), .o_peripheral_irq(irq));
  acs_analog_model ana (.i_clock(i_clock), .i_sample(samp), .i_channel_sel(chan),
    .i_dac_code(dac), .o_comp_high(comp));

  // free-running system clock
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge i_clock);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= wr;
    i_paddr   <= {2'b00, idx, 2'b00};
    i_pwdata  <= {24'h0000_00, wd};
    @(posedge i_clock);
    i_penable <= 1'b1;
    @(posedge i_clock);
    while (o_pready !== 1'b1) @(posedge i_clock);
    rd = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h0000_00, exp});
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // start a conversion, time it and check the stored result
  task automatic conv(input logic [1:0] sel, input logic [4:0] ch, input logic j);
    int d;
    d = 8 << sel;
    if (sel == 2'h3) d = 128;
    last = {ch, 7'h35};
    apb(1'b1, CTL1_IDX, {j, ch[4], 6'h00});
    apb(1'b1, CTL0_IDX, {sel, ch[3:0], 2'b01});
    #1 chk(ref_sh, ch == 5'h12);
    apb(1'b1, CTL0_IDX, {sel, ch[3:0], 2'b11});
    repeat (49 * d - 8) @(posedge i_clock);
    rdchk(CTL0_IDX, {sel, ch[3:0], 2'b11});
    repeat (5) @(posedge i_clock);
    rdchk(CTL0_IDX, {sel, ch[3:0], 2'b01});
    rdchk(FLAG_IDX, 8'h40);
    rdchk(RESH_IDX, j ? {6'h00, last[11:10]} : last[11:4]);
    rdchk(RESL_IDX, j ? last[9:2] : {last[3:0], 4'h0});
  endtask

  // done flag, its enable and the interrupt request
  task automatic flag_irq();
    chk(irq, 1'b0);
    apb(1'b1, IEN_IDX, 8'h40);
    repeat (40) @(posedge i_clock);
    rdchk(FLAG_IDX, 8'h40);
    chk(irq, 1'b1);
    apb(1'b1, FLAG_IDX, 8'h00);
    @(posedge i_clock);
    chk(irq, 1'b0);
  endtask

  // abort in mid-run: result kept, two-period wait, acquisition resumes
  task automatic abort_run();
    apb(1'b1, CTL0_IDX, 8'h0F);
    repeat (100) @(posedge i_clock);
    apb(1'b1, CTL0_IDX, 8'h0F);
    apb(1'b1, CTL0_IDX, 8'h0D);
    repeat (2) @(posedge i_clock);
    #1 chk(samp, 1'b0);
    repeat (18) @(posedge i_clock);
    #1 chk(samp, 1'b1);
    repeat (400) @(posedge i_clock);
    rdchk(RESL_IDX, {last[3:0], 4'h0});
    rdchk(FLAG_IDX, 8'h00);
  endtask

  // go refused when off, in the enabling write, or in sleep; reset stops a run
  task automatic refusals();
    apb(1'b1, CTL0_IDX, 8'h00);
    apb(1'b1, CTL0_IDX, 8'h03);
    rdchk(CTL0_IDX, 8'h01);
    i_sleep <= 1'b1;
    apb(1'b1, CTL0_IDX, 8'h03);
    rdchk(CTL0_IDX, 8'h01);
    i_sleep <= 1'b0;
    apb(1'b1, CTL0_IDX, 8'h03);
    repeat (30) @(posedge i_clock);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_reset <= 1'b0;
    rdchk(CTL0_IDX, 8'h00);
    chk(on, 1'b0);
  endtask

  // hang guard: whole run is about 31k cycles
  initial begin
    #500_000;
    n_errors++;
    summarize();
  end

  initial begin
    {i_psel, i_penable, i_pwrite, i_sleep} = 4'h0;
    i_paddr = 12'h000;
    i_pwdata = 32'h0000_0000;
    i_reset = 1'b1;
    repeat (4) @(posedge i_clock);
    i_reset <= 1'b0;
    rdchk(CTL0_IDX, 8'h00);
    rdchk(CTL1_IDX, 8'h00);
    rdchk(8'h01, 8'h00);
    chk(err, 1'b1);
    // internal reference on at the lower level, then the settling wait
    apb(1'b1, CTL1_IDX, 8'h05);
    rdchk(CTL1_IDX, 8'h05);
    chk(ldo_en, 1'b1);
    chk(ldo_sel, 1'b1);
    repeat (20_000) @(posedge i_clock);
    for (int s = 0; s < 4; s++) conv(s[1:0], s[4:0] + 5'h01, 1'b0);
    conv(2'h1, 5'h12, 1'b1);
    flag_irq();
    conv(2'h0, 5'h03, 1'b0);
    apb(1'b1, FLAG_IDX, 8'h00);
    abort_run();
    refusals();
    summarize();
  end
endmodule
